// [bench/sfsr_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module sfsr_chk (
    // clock, reset and register access
    input wire logic mclk, rst_n, reg_sel, reg_wr, reg_rd, reg_rvalid_r, reg_wr_refused_r,
    input wire logic [23:0] reg_wdata, reg_rdata_r,
    // flags and summaries
    input wire logic wrong_refresh_answer, refresh_window_violation, refresh_error_summary,
    input wire logic power_good_pin_diag, reset_pin_diag, safe_output_pin_diag,
    input wire logic safety_pin_error_summary,
    // selftest
    input wire logic analog_selftest_phase2, core_monitor_selftest_sel,
    input wire logic io_monitor_selftest_sel, core_bist_run_r
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // summaries are the group or one cycle late, skipped on the first edge out of reset
    chk_refresh_or: assert property ($past(rst_n) |->
        refresh_error_summary == $past(wrong_refresh_answer | refresh_window_violation))
        else $error("refresh summary mismatch");
    chk_pin_or: assert property ($past(rst_n) |-> safety_pin_error_summary ==
        $past(power_good_pin_diag | reset_pin_diag | safe_output_pin_diag))
        else $error("pin summary mismatch");
    // a summary may only drop once all its flags are clear
    chk_refresh_clear: assert property ($past(rst_n) && $fell(refresh_error_summary) |->
        $past(!wrong_refresh_answer && !refresh_window_violation))
        else $error("refresh summary dropped early");
    // config write lands at the taking edge
    chk_sel_write: assert property (reg_wr && reg_sel |=>
        core_monitor_selftest_sel == $past(reg_wdata[18]) &&
        io_monitor_selftest_sel == $past(reg_wdata[17]))
        else $error("selftest select not stored");
    chk_core_run: assert property ($past(rst_n) |->
        core_bist_run_r == $past(analog_selftest_phase2 & core_monitor_selftest_sel))
        else $error("core selftest run mismatch");
    // handshake pulses of the register port
    chk_refuse_pulse: assert property ($past(rst_n) |->
        reg_wr_refused_r == $past(reg_wr & ~reg_sel))
        else $error("refused pulse mismatch");
    chk_read_valid: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read valid missing");
    chk_reserved_zero: assert property (reg_rvalid_r |->
        reg_rdata_r[19] == 1'b0 && reg_rdata_r[12] == 1'b0 && reg_rdata_r[7:0] == 8'h00)
        else $error("reserved read bits not zero");
endmodule // sfsr_chk
bind sfsr_regs sfsr_chk i_chk (.mclk, .rst_n, .reg_sel, .reg_wr, .reg_rd, .reg_rvalid_r,
    .reg_wr_refused_r, .reg_wdata, .reg_rdata_r, .wrong_refresh_answer,
    .refresh_window_violation, .refresh_error_summary, .power_good_pin_diag, .reset_pin_diag,
    .safe_output_pin_diag, .safety_pin_error_summary, .analog_selftest_phase2,
    .core_monitor_selftest_sel, .io_monitor_selftest_sel, .core_bist_run_r);
`default_nettype wire

// [bench/sfsr_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ph2 = 1'b0;
    logic [23:0] wdata = 24'h000000;
    logic [21:0] fl = 22'h000000;
    wire [23:0] rdata;
    wire rvalid, refused, s_com, s_ref, s_pin, s_volt, r_core, r_io;
    wire [5:0] sels;
    wire [7:0] react;
    wire [3:0] r_mon;
    wire [3:0] sums = {s_com, s_ref, s_pin, s_volt};
    wire [5:0] runs = {r_core, r_io, r_mon[0], r_mon[1], r_mon[2], r_mon[3]};
    int mismatches = 0;
    int n_checks = 0;
    int i;
    logic [3:0] e4;
    // flags: 0..4 link, 5..6 refresh, 7..9 pins, 10..21 voltage monitors
    sfsr_regs i_dut (.mclk(mclk), .rst_n(rst_n), .reg_sel(sel), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid), .reg_wr_refused_r(refused),
        .serial_clock_count_error(fl[0]), .serial_request_error(fl[1]),
        .serial_checksum_error(fl[2]), .twowire_checksum_error(fl[3]),
        .twowire_request_error(fl[4]), .wrong_refresh_answer(fl[5]),
        .refresh_window_violation(fl[6]), .power_good_pin_diag(fl[7]), .reset_pin_diag(fl[8]),
        .safe_output_pin_diag(fl[9]), .core_overvolt_flag(fl[10]), .core_undervolt_flag(fl[11]),
        .io_overvolt_flag(fl[12]), .io_undervolt_flag(fl[13]), .monitor1_overvolt_flag(fl[14]),
        .monitor1_undervolt_flag(fl[15]), .monitor2_overvolt_flag(fl[16]),
        .monitor2_undervolt_flag(fl[17]), .monitor3_overvolt_flag(fl[18]),
        .monitor3_undervolt_flag(fl[19]), .monitor4_overvolt_flag(fl[20]),
        .monitor4_undervolt_flag(fl[21]), .analog_selftest_phase2(ph2),
        .comm_error_summary(s_com), .refresh_error_summary(s_ref),
        .safety_pin_error_summary(s_pin), .voltage_fault_summary(s_volt),
        .core_monitor_selftest_sel(sels[5]), .io_monitor_selftest_sel(sels[4]),
        .monitor1_selftest_sel(sels[3]), .monitor2_selftest_sel(sels[2]),
        .monitor3_selftest_sel(sels[1]), .monitor4_selftest_sel(sels[0]),
        .core_overvolt_reaction(react[7:6]), .core_undervolt_reaction(react[5:4]),
        .io_overvolt_reaction(react[3:2]), .io_undervolt_reaction(react[1:0]),
        .core_bist_run_r(r_core), .io_bist_run_r(r_io), .monitor_bist_run_r(r_mon));
    // compare one result word, all results padded to the register width
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one-cycle write strobe; summary writes must come back refused
    task automatic wr_reg(input logic s, input logic [23:0] d);
        @(negedge mclk);
        sel = s;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk);
        wr = 1'b0;
        cmp({23'h0, refused}, {23'h0, ~s});
    endtask
    // one-cycle read strobe; valid and data are looked at in the answer cycle
    task automatic rd_reg(input logic s, input logic [23:0] exp);
        @(negedge mclk);
        sel = s;
        rd = 1'b1;
        @(negedge mclk);
        rd = 1'b0;
        cmp({23'h0, rvalid}, 24'h000001);
        cmp(rdata, exp);
    endtask
    // clock and watchdog
    always #10 mclk = ~mclk;
    initial begin
        #200000;
        mismatches++;
        wrap_up;
    end
    // main sequence
    initial begin
        repeat (5) @(negedge mclk);
        cmp({20'h0, sums}, 24'h000001);
        rst_n = 1'b1;
        rd_reg(1'b1, 24'hd00d00);
        rd_reg(1'b0, 24'h000000);
        // each flag alone raises only its own group bit
        for (i = 0; i < 22; i++) begin
            @(negedge mclk);
            fl = 22'h1 << i;
            e4 = (i < 5) ? 4'h8 : (i < 7) ? 4'h4 : (i < 10) ? 4'h2 : 4'h1;
            rd_reg(1'b0, {e4, 20'h0});
            cmp({20'h0, sums}, {20'h0, e4});
        end
        // two flags of one group: the bit drops only when both are gone
        @(negedge mclk);
        fl = 22'h000060;
        @(negedge mclk);
        fl = 22'h000040;
        rd_reg(1'b0, 24'h400000);
        @(negedge mclk);
        fl = 22'h000000;
        rd_reg(1'b0, 24'h000000);
        // reserved bits drop, summary writes are refused
        wr_reg(1'b1, 24'hffffff);
        rd_reg(1'b1, 24'hf7ef00);
        wr_reg(1'b0, 24'h000000);
        rd_reg(1'b1, 24'hf7ef00);
        rd_reg(1'b0, 24'h000000);
        wr_reg(1'b1, 24'h900600);
        rd_reg(1'b1, 24'h900600);
        cmp({16'h0, react}, 24'h000096);
        // walk each selftest select while phase 2 runs
        ph2 = 1'b1;
        for (i = 13; i < 19; i++) begin
            wr_reg(1'b1, 24'h1 << i);
            @(negedge mclk);
            cmp({18'h0, sels}, 24'h1 << (i - 13));
            cmp({18'h0, runs}, 24'h1 << (i - 13));
            rd_reg(1'b1, 24'h1 << i);
        end
        // no test runs outside phase 2 even with a select set
        ph2 = 1'b0;
        repeat (2) @(negedge mclk);
        cmp({18'h0, runs}, 24'h000000);
        // a second power-on reset clears the selects set above
        rst_n = 1'b0;
        @(negedge mclk);
        cmp({20'h0, sums}, 24'h000001);
        cmp({18'h0, sels}, 24'h000000);
        rst_n = 1'b1;
        rd_reg(1'b1, 24'hd00d00);
        wrap_up;
    end
endmodule // tb
`default_nettype wire

// [design/sfsr_defs.vh]
// Summary of operation
// - comm summary bit23 ORs five link errors
// - refresh summary bit22 ORs two watchdog errors
// - safety pin summary bit21 ORs three diags
// - voltage summary bit20 ORs twelve monitor flags
// - summaries follow sources one cycle late, never latched
// - bits18,17 select core/io monitor selftest
// - bits16..13 select monitors one to four
// - bit18 set enables core monitor selftest while phase 2 runs
`ifndef SFSR_DEFS_VH
`define SFSR_DEFS_VH

// register selection codes
`define SFSR_IDX_SUMMARY 1'b0
`define SFSR_IDX_CFG 1'b1

// register word width (bits 7:0 always read zero)
`define SFSR_DW 24

// summary register field positions
`define SFSR_POS_COMM 23
`define SFSR_POS_REFRESH 22
`define SFSR_POS_PIN 21
`define SFSR_POS_VOLT 20

// summary reset value, ordered comm, refresh, pin, volt
`define SFSR_SUM_RST 4'h1

// configuration register field positions
`define SFSR_POS_CORE_OV_HI 23
`define SFSR_POS_CORE_OV_LO 22
`define SFSR_POS_CORE_UV_HI 21
`define SFSR_POS_CORE_UV_LO 20
`define SFSR_POS_SEL_CORE 18
`define SFSR_POS_SEL_IO 17
`define SFSR_POS_SEL_MON1 16
`define SFSR_POS_SEL_MON2 15
`define SFSR_POS_SEL_MON3 14
`define SFSR_POS_SEL_MON4 13
`define SFSR_POS_IO_OV_HI 11
`define SFSR_POS_IO_OV_LO 10
`define SFSR_POS_IO_UV_HI 9
`define SFSR_POS_IO_UV_LO 8

// configuration reset values
`define SFSR_OV_RST 2'h3
`define SFSR_UV_RST 2'h1
`define SFSR_SEL_RST 1'b0

`endif

// [design/sfsr_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_defs.vh"

module sfsr_regs (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // register access from the serial control interface
    input wire reg_sel,
    input wire reg_wr,
    input wire reg_rd,
    input wire [23:0] reg_wdata,
    output reg [23:0] reg_rdata_r,
    output reg reg_rvalid_r,
    output reg reg_wr_refused_r,
    // communication error flags
    input wire serial_clock_count_error,
    input wire serial_request_error,
    input wire serial_checksum_error,
    input wire twowire_checksum_error,
    input wire twowire_request_error,
    // watchdog refresh error flags
    input wire wrong_refresh_answer,
    input wire refresh_window_violation,
    // safety pin diagnostic flags
    input wire power_good_pin_diag,
    input wire reset_pin_diag,
    input wire safe_output_pin_diag,
    // voltage monitor flags
    input wire core_overvolt_flag,
    input wire core_undervolt_flag,
    input wire io_overvolt_flag,
    input wire io_undervolt_flag,
    input wire monitor1_overvolt_flag,
    input wire monitor1_undervolt_flag,
    input wire monitor2_overvolt_flag,
    input wire monitor2_undervolt_flag,
    input wire monitor3_overvolt_flag,
    input wire monitor3_undervolt_flag,
    input wire monitor4_overvolt_flag,
    input wire monitor4_undervolt_flag,
    // selftest sequencing
    input wire analog_selftest_phase2,
    // live summary outputs
    output wire comm_error_summary,
    output wire refresh_error_summary,
    output wire safety_pin_error_summary,
    output wire voltage_fault_summary,
    // configuration outputs
    output reg core_monitor_selftest_sel,
    output reg io_monitor_selftest_sel,
    output reg monitor1_selftest_sel,
    output reg monitor2_selftest_sel,
    output reg monitor3_selftest_sel,
    output reg monitor4_selftest_sel,
    output reg [1:0] core_overvolt_reaction,
    output reg [1:0] core_undervolt_reaction,
    output reg [1:0] io_overvolt_reaction,
    output reg [1:0] io_undervolt_reaction,
    // per-monitor test enables during selftest phase 2
    output reg core_bist_run_r,
    output reg io_bist_run_r,
    output reg [3:0] monitor_bist_run_r
);

    wire [3:0] summary_w;
    wire cfg_wr;
    wire sum_wr;
    reg [23:0] rd_nxt;
    reg [23:0] sum_word;
    reg [23:0] cfg_word;

    // summary builder, one flop stage
    sfsr_summary u_summary (
        .mclk(mclk),
        .rst_n(rst_n),
        .comm_flags({serial_clock_count_error, serial_request_error,
            serial_checksum_error, twowire_checksum_error, twowire_request_error}),
        .refresh_flags({wrong_refresh_answer, refresh_window_violation}),
        .pin_flags({power_good_pin_diag, reset_pin_diag, safe_output_pin_diag}),
        .volt_flags({core_overvolt_flag, core_undervolt_flag,
            io_overvolt_flag, io_undervolt_flag,
            monitor1_overvolt_flag, monitor1_undervolt_flag,
            monitor2_overvolt_flag, monitor2_undervolt_flag,
            monitor3_overvolt_flag, monitor3_undervolt_flag,
            monitor4_overvolt_flag, monitor4_undervolt_flag}),
        .summary_r(summary_w)
    );

    // summary bits straight from the builder flops
    assign comm_error_summary = summary_w[3];
    assign refresh_error_summary = summary_w[2];
    assign safety_pin_error_summary = summary_w[1];
    assign voltage_fault_summary = summary_w[0];

    // write decode
    assign cfg_wr = reg_wr & (reg_sel == `SFSR_IDX_CFG);
    assign sum_wr = reg_wr & (reg_sel == `SFSR_IDX_SUMMARY);

    // configuration storage; reserved bits 19 and 12 are never stored
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_monitor_selftest_sel <= `SFSR_SEL_RST;
            io_monitor_selftest_sel <= `SFSR_SEL_RST;
            monitor1_selftest_sel <= `SFSR_SEL_RST;
            monitor2_selftest_sel <= `SFSR_SEL_RST;
            monitor3_selftest_sel <= `SFSR_SEL_RST;
            monitor4_selftest_sel <= `SFSR_SEL_RST;
            core_overvolt_reaction <= `SFSR_OV_RST;
            core_undervolt_reaction <= `SFSR_UV_RST;
            io_overvolt_reaction <= `SFSR_OV_RST;
            io_undervolt_reaction <= `SFSR_UV_RST;
        end else if (cfg_wr) begin
            core_monitor_selftest_sel <= reg_wdata[`SFSR_POS_SEL_CORE];
            io_monitor_selftest_sel <= reg_wdata[`SFSR_POS_SEL_IO];
            monitor1_selftest_sel <= reg_wdata[`SFSR_POS_SEL_MON1];
            monitor2_selftest_sel <= reg_wdata[`SFSR_POS_SEL_MON2];
            monitor3_selftest_sel <= reg_wdata[`SFSR_POS_SEL_MON3];
            monitor4_selftest_sel <= reg_wdata[`SFSR_POS_SEL_MON4];
            core_overvolt_reaction <=
                reg_wdata[`SFSR_POS_CORE_OV_HI:`SFSR_POS_CORE_OV_LO];
            core_undervolt_reaction <=
                reg_wdata[`SFSR_POS_CORE_UV_HI:`SFSR_POS_CORE_UV_LO];
            io_overvolt_reaction <=
                reg_wdata[`SFSR_POS_IO_OV_HI:`SFSR_POS_IO_OV_LO];
            io_undervolt_reaction <=
                reg_wdata[`SFSR_POS_IO_UV_HI:`SFSR_POS_IO_UV_LO];
        end
    end

    // monitors under test: selected and phase 2 running
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_bist_run_r <= 1'b0;
            io_bist_run_r <= 1'b0;
            monitor_bist_run_r <= 4'h0;
        end else begin
            core_bist_run_r <= analog_selftest_phase2 & core_monitor_selftest_sel;
            io_bist_run_r <= analog_selftest_phase2 & io_monitor_selftest_sel;
            monitor_bist_run_r <= {4{analog_selftest_phase2}} &
                {monitor4_selftest_sel, monitor3_selftest_sel,
                monitor2_selftest_sel, monitor1_selftest_sel};
        end
    end

    // read images; unlisted bits stay zero
    always @* begin
        sum_word = 24'h000000;
        sum_word[`SFSR_POS_COMM] = summary_w[3];
        sum_word[`SFSR_POS_REFRESH] = summary_w[2];
        sum_word[`SFSR_POS_PIN] = summary_w[1];
        sum_word[`SFSR_POS_VOLT] = summary_w[0];
        cfg_word = 24'h000000;
        cfg_word[`SFSR_POS_CORE_OV_HI:`SFSR_POS_CORE_OV_LO] = core_overvolt_reaction;
        cfg_word[`SFSR_POS_CORE_UV_HI:`SFSR_POS_CORE_UV_LO] = core_undervolt_reaction;
        cfg_word[`SFSR_POS_SEL_CORE] = core_monitor_selftest_sel;
        cfg_word[`SFSR_POS_SEL_IO] = io_monitor_selftest_sel;
        cfg_word[`SFSR_POS_SEL_MON1] = monitor1_selftest_sel;
        cfg_word[`SFSR_POS_SEL_MON2] = monitor2_selftest_sel;
        cfg_word[`SFSR_POS_SEL_MON3] = monitor3_selftest_sel;
        cfg_word[`SFSR_POS_SEL_MON4] = monitor4_selftest_sel;
        cfg_word[`SFSR_POS_IO_OV_HI:`SFSR_POS_IO_OV_LO] = io_overvolt_reaction;
        cfg_word[`SFSR_POS_IO_UV_HI:`SFSR_POS_IO_UV_LO] = io_undervolt_reaction;
        case (reg_sel)
            `SFSR_IDX_SUMMARY: rd_nxt = sum_word;
            `SFSR_IDX_CFG: rd_nxt = cfg_word;
            default: rd_nxt = 24'h000000;
        endcase
    end

    // read answer one cycle after the strobe; old value if written same cycle
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 24'h000000;
            reg_rvalid_r <= 1'b0;
            reg_wr_refused_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            reg_wr_refused_r <= sum_wr; // summary is read only
            if (reg_rd) begin
                reg_rdata_r <= rd_nxt;
            end
        end
    end

endmodule // sfsr_regs
`default_nettype wire

// [design/sfsr_summary.v]
`timescale 1ns/1ps
`default_nettype none
`include "sfsr_defs.vh"

module sfsr_summary (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // grouped detailed flags
    input wire [4:0] comm_flags,
    input wire [1:0] refresh_flags,
    input wire [2:0] pin_flags,
    input wire [11:0] volt_flags,
    // summary bits: comm, refresh, pin, volt
    output reg [3:0] summary_r
);

    reg [3:0] summary_nxt;

    // live or of each group, no memory of past faults
    always @* begin
        summary_nxt[3] = |comm_flags;
        summary_nxt[2] = |refresh_flags;
        summary_nxt[1] = |pin_flags;
        summary_nxt[0] = |volt_flags;
    end

    // registered every cycle so it drops on the edge after all sources clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            summary_r <= `SFSR_SUM_RST;
        end else begin
            summary_r <= summary_nxt;
        end
    end

endmodule // sfsr_summary
`default_nettype wire
